// *** hw/waveform_timer_control.sv ***
// Waveform timer control: APB registers, counter, waveforms, interrupts

module waveform_timer_control
    import waveform_timer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic      [2:0]  woPin,
    output logic      [2:0]  woPinEn,
    output logic      [2:0]  woLogic
);

    // ==================================================================
    // Declarations
    apb_req_t    req;            // Bundled bus request
    logic [7:0]  idx;            // Register index from the address
    logic        wrEn;           // Write takes effect this edge
    logic [31:0] rdNext;         // Read mux output
    logic        rdErr;          // Unmapped index
    logic [3:0]  ctrlA;          // Clock select and enable
    logic [6:0]  ctrlB;          // Channel enables and mode
    logic [2:0]  outVal;         // channel_output_value bits
    logic        splitSel;       // split_select
    logic [7:0]  mask;           // Interrupt mask
    logic [7:0]  flags;          // Sticky interrupt status
    logic        updateLock;     // update_lock
    logic        dir;            // One counts down
    logic [15:0] cnt;            // Counter
    logic [15:0] cntNext;        // Next count in 16-bit mode
    logic [9:0]  pre;            // Prescaler
    logic        tick;           // Prescaled count strobe
    logic        enable;         // Timer running
    logic [2:0]  clkSel;         // Prescaler choice
    wave_mode_t  mode;           // waveform_mode_select
    logic [2:0]  chanEn;         // channel_output_enable bits
    logic        dual;           // Dual ramp mode
    logic [15:0] top;            // Active top value
    logic        run16;          // Counting in 16-bit mode
    logic        wrapUp;         // Top reached while counting up
    logic        wrapDown;       // Bottom reached while counting down
    logic        splitUf;        // Low byte underflow in split mode
    logic        updEvt;         // Hardware update condition
    logic        ovfEvt;         // Overflow condition
    logic [2:0]  cmpHit;         // Compare matches
    logic        cmdWr;          // Write to either control E alias
    command_t    cmd;            // Command written
    logic        forceUpd;       // Forced update
    logic        restart;        // Forced restart
    logic        hardRst;        // Accepted hard reset
    logic        doUpdate;       // Buffers transfer this edge
    logic        eWrSet;         // Write to set alias
    logic        eWrClr;         // Write to clear alias
    logic [15:0] actVal [4];     // Period and compare values
    logic [15:0] bufVal [4];     // Their buffers
    logic [3:0]  bufValid;       // period_buffer_valid, compare_buffer_valid
    logic [2:0]  wgOut;          // Waveform generator outputs

    // ==================================================================
    // Bus decode
    assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign idx     = req.addr[9:2];
    assign wrEn    = psel & penable & req.write & pready;
    assign eWrSet  = wrEn & (idx == IDX_ESET);
    assign eWrClr  = wrEn & (idx == IDX_ECLR);
    assign cmdWr   = eWrSet | eWrClr;
    assign cmd     = command_t'(req.wdata[CMD_LSB +: 2]);
    assign enable  = ctrlA[0];
    assign clkSel  = ctrlA[CLKSEL_LSB +: 3];
    assign mode    = wave_mode_t'(ctrlB[2:0]);
    assign chanEn  = ctrlB[CHEN_LSB +: 3];
    // Commands act on the write itself
    assign forceUpd = cmdWr & (cmd == CMD_UPDATE);
    assign restart  = cmdWr & (cmd == CMD_RESTART);
    assign hardRst  = cmdWr & (cmd == CMD_HARD) & ~enable;

    // Read mux; command bits never stored so they read zero
    always_comb begin
        rdNext = 32'h0000_0000;
        rdErr  = 1'b0;
        case (idx)
            IDX_CTRLA:  rdNext[3:0] = ctrlA;
            IDX_CTRLB:  rdNext[6:0] = ctrlB;
            IDX_OUTVAL: rdNext[2:0] = outVal;
            IDX_SPLIT:  rdNext[0]   = splitSel;
            IDX_ECLR, IDX_ESET: begin
                rdNext[LOCK_BIT] = updateLock;
                rdNext[DIR_BIT]  = dir;
            end
            IDX_FCLR, IDX_FSET: rdNext[3:0] = bufValid;
            IDX_MASK:   rdNext[7:0]  = mask;
            IDX_FLAGS:  rdNext[7:0]  = flags;
            IDX_CNT:    rdNext[15:0] = cnt;
            default: begin
                rdErr = 1'b1;
                for (int e = 0; e < 4; e++) begin
                    if (idx == ACT_IDX[e]) begin
                        rdNext[15:0] = actVal[e];
                        rdErr        = 1'b0;
                    end
                    if (idx == BUF_IDX[e]) begin
                        rdNext[15:0] = bufVal[e];
                        rdErr        = 1'b0;
                    end
                end
            end
        endcase
    end

    // APB answer: one wait-free access cycle after setup
    always_ff @(posedge clock) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pready  <= 1'b1;
            prdata  <= req.write ? 32'h0000_0000 : rdNext;
            pslverr <= rdErr;
        end else begin
            // Answer lasts exactly one access cycle
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ==================================================================
    // Plain control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrlA    <= CTRL_RST[3:0];
            ctrlB    <= CTRL_RST[6:0];
            outVal   <= CTRL_RST[2:0];
            splitSel <= 1'b0;
            mask     <= CTRL_RST;
        end else if (wrEn) begin
            if (idx == IDX_CTRLA) ctrlA <= req.wdata[3:0];
            if (idx == IDX_CTRLB) ctrlB <= req.wdata[6:0];
            if (idx == IDX_OUTVAL) outVal <= req.wdata[2:0];
            if (idx == IDX_SPLIT) splitSel <= req.wdata[0];
            if (idx == IDX_MASK) begin
                mask <= req.wdata[7:0] & 8'h71;
            end
        end
    end

    // Update lock: set and clear aliases touch only ones
    always_ff @(posedge clock) begin
        if (srst | hardRst) begin
            updateLock <= 1'b0;
        end else if (eWrSet & req.wdata[LOCK_BIT]) begin
            updateLock <= 1'b1;
        end else if (eWrClr & req.wdata[LOCK_BIT]) begin
            updateLock <= 1'b0;
        end
    end

    // ==================================================================
    // Prescaler; restarted at zero so the first count comes on the next edge
    always_ff @(posedge clock) begin
        if (srst | ~enable | restart | hardRst) begin
            pre <= 10'h000;
        end else begin
            pre <= pre + 10'h001;
        end
    end
    assign tick = ((pre & DIV_MASK[clkSel]) == 10'h000);

    // ==================================================================
    // Count sequence and events
    assign dual  = mode[2];
    assign top   = (mode == FREQUENCY_MODE) ? actVal[1]
                                            : actVal[0];
    assign run16 = enable & tick & ~splitSel;
    assign wrapUp   = run16 & ~dir & (cnt >= top);
    assign wrapDown = run16 & dir & (cnt == 16'h0000);
    assign splitUf  = enable & tick & splitSel & (cnt[7:0] == 8'h00);

    // Update and overflow points per mode
    always_comb begin
        if (dual) begin
            updEvt = wrapDown;
            case (mode)
                DUAL_RAMP_OVF_HIGH: ovfEvt = wrapUp;
                DUAL_RAMP_OVF_BOTH: ovfEvt = wrapUp | wrapDown;
                default:            ovfEvt = wrapDown;
            endcase
        end else begin
            // Top counting up, bottom counting down
            updEvt = wrapUp | wrapDown;
            ovfEvt = wrapUp | wrapDown;
        end
    end

    // Next count; dual ramp turns round instead of wrapping
    always_comb begin
        if (~dir) begin
            if (cnt >= top) begin
                cntNext = dual ? cnt - 16'h0001 : 16'h0000;
            end else begin
                cntNext = cnt + 16'h0001;
            end
        end else if (cnt == 16'h0000) begin
            cntNext = dual ? 16'h0001 : top;
        end else begin
            cntNext = cnt - 16'h0001;
        end
    end

    // Counter and direction
    always_ff @(posedge clock) begin
        if (srst | hardRst | restart) begin
            cnt <= 16'h0000;
            dir <= 1'b0;
        end else begin
            if (enable & tick & splitSel) begin
                // Two independent 8-bit down counters
                cnt[7:0]  <= (cnt[7:0] == 8'h00) ? actVal[0][7:0]
                                                 : cnt[7:0] - 8'h01;
                cnt[15:8] <= (cnt[15:8] == 8'h00) ? actVal[0][15:8]
                                                  : cnt[15:8] - 8'h01;
            end else if (run16) begin
                cnt <= cntNext;
            end
            // Software writes win over hardware turnaround
            if (eWrSet & req.wdata[DIR_BIT]) begin
                dir <= 1'b1;
            end else if (eWrClr & req.wdata[DIR_BIT]) begin
                dir <= 1'b0;
            end else if (dual & (wrapUp | wrapDown)) begin
                dir <= ~dir;
            end
        end
    end

    // ==================================================================
    // Buffered period and compare entries
    assign doUpdate = (updEvt & ~updateLock) | forceUpd;

    for (genvar e = 0; e < 4; e++) begin : g_entry
        logic bufWr; // Buffer written this edge
        logic actWr; // Active value written directly
        assign bufWr = wrEn & (idx == BUF_IDX[e]);
        assign actWr = wrEn & (idx == ACT_IDX[e]);

        always_ff @(posedge clock) begin
            if (srst | hardRst) begin
                actVal[e] <= ACT_RST[e];
                bufVal[e] <= BUF_RST;
            end else begin
                if (bufWr) bufVal[e] <= req.wdata[15:0];
                if (actWr) begin
                    actVal[e] <= req.wdata[15:0];
                end else if (doUpdate & bufValid[e]) begin
                    actVal[e] <= bufVal[e];
                end
            end
        end

        // A fresh write wins over a simultaneous update
        always_ff @(posedge clock) begin
            if (srst | hardRst) begin
                bufValid[e] <= 1'b0;
            end else if (bufWr) begin
                bufValid[e] <= 1'b1;
            end else if (wrEn & (idx == IDX_FSET) & req.wdata[e]) begin
                bufValid[e] <= 1'b1;
            end else if (doUpdate) begin
                bufValid[e] <= 1'b0;
            end else if (wrEn & (idx == IDX_FCLR) & req.wdata[e]) begin
                bufValid[e] <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Waveform generation per channel
    for (genvar i = 0; i < 3; i++) begin : g_wave
        assign cmpHit[i] = run16 & (cnt == actVal[i + 1]);

        always_ff @(posedge clock) begin
            if (srst | hardRst) begin
                wgOut[i] <= 1'b0;
            end else if (~enable) begin
                wgOut[i] <= outVal[i];
            end else if (~splitSel) begin
                if (mode == FREQUENCY_MODE) begin
                    if (cmpHit[i]) wgOut[i] <= ~wgOut[i];
                end else if (mode != WG_NORMAL) begin
                    wgOut[i] <= (cnt < actVal[i + 1]);
                end
            end
        end
    end

    // Pin drive; the logic-block path ignores the enables
    always_ff @(posedge clock) begin
        if (srst) begin
            woPin   <= 3'h0;
            woPinEn <= 3'h0;
            woLogic <= 3'h0;
        end else begin
            woPin   <= wgOut;
            // Normal mode keeps pins off while running
            woPinEn <= chanEn & {3{~splitSel &
                       (~enable | (mode != WG_NORMAL))}};
            woLogic <= wgOut;
        end
    end

    // ==================================================================
    // Interrupts: set wins over write-one-to-clear
    always_ff @(posedge clock) begin
        if (srst) begin
            flags <= 8'h00;
        end else begin
            flags <= (flags & ~((wrEn & (idx == IDX_FLAGS))
                              ? req.wdata[7:0] : 8'h00))
                   | {1'b0, cmpHit, 3'b000, ovfEvt | splitUf};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) irq <= 1'b0;
        else      irq <= |(flags & mask);
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_cmd_zero;
        psel & penable & ~pwrite & pready &
        ((idx == IDX_ECLR) | (idx == IDX_ESET)) |-> prdata[3:2] == 2'b00;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero)
        else $error("command field read nonzero");

    property p_clr_lock;
        eWrClr & req.wdata[LOCK_BIT] & ~hardRst |=> ~updateLock;
    endproperty
    a_clr_lock: assert property (p_clr_lock)
        else $error("clear alias left lock set");

    property p_keep_lock;
        eWrClr & ~req.wdata[LOCK_BIT] & ~hardRst |=> $stable(updateLock);
    endproperty
    a_keep_lock: assert property (p_keep_lock)
        else $error("clear alias changed unwritten bit");

    property p_set_dir;
        eWrSet & req.wdata[DIR_BIT] & ~cmd[1] |=> dir;
    endproperty
    a_set_dir: assert property (p_set_dir)
        else $error("set alias did not set direction");

    property p_force;
        forceUpd & bufValid[0] |=> actVal[0] == $past(bufVal[0]);
    endproperty
    a_force: assert property (p_force)
        else $error("forced update did not transfer");

    property p_lock;
        updateLock & updEvt & ~wrEn |=> $stable(actVal[0]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked update transferred");

    property p_hard;
        hardRst |=> (cnt == 16'h0000) && (bufValid == 4'h0);
    endproperty
    a_hard: assert property (p_hard)
        else $error("hard reset incomplete");

    property p_normal;
        enable & (mode == WG_NORMAL) |=> woPinEn == 3'h0;
    endproperty
    a_normal: assert property (p_normal)
        else $error("pin driven in normal mode");

    property p_override;
        // A hard reset zeroes the generator instead of copying the override
        ~enable & ~hardRst ##1 ~enable |=> woLogic == $past(outVal, 2);
    endproperty
    a_override: assert property (p_override)
        else $error("override value not on output");

    property p_valid;
        wrEn & (idx == BUF_IDX[0]) & ~hardRst |=> bufValid[0];
    endproperty
    a_valid: assert property (p_valid)
        else $error("buffer valid not set");

endmodule // waveform_timer_control

// *** hw/waveform_timer_pkg.sv ***
// Constants, register map and carrier types of the waveform timer control
package waveform_timer_pkg;

    // ==================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRLA  = 8'h00; // Enable and clock select
    localparam logic [7:0] IDX_CTRLB  = 8'h01; // Channel enables and mode
    localparam logic [7:0] IDX_OUTVAL = 8'h02; // output_value_control
    localparam logic [7:0] IDX_SPLIT  = 8'h03; // split_mode_control
    localparam logic [7:0] IDX_ECLR   = 8'h04; // command_lock_dir_clear
    localparam logic [7:0] IDX_ESET   = 8'h05; // command_lock_dir_set
    localparam logic [7:0] IDX_FCLR   = 8'h06; // buffer_valid_clear
    localparam logic [7:0] IDX_FSET   = 8'h07; // Buffer valid set alias
    localparam logic [7:0] IDX_MASK   = 8'h0A; // Interrupt mask
    localparam logic [7:0] IDX_FLAGS  = 8'h0B; // Sticky interrupt status
    localparam logic [7:0] IDX_CNT    = 8'h20; // Counter, read only
    // Entry 0 is the period, entries 1..3 the compare channels
    localparam logic [7:0] ACT_IDX [4] = '{8'h26, 8'h28, 8'h2A, 8'h2C};
    localparam logic [7:0] BUF_IDX [4] = '{8'h36, 8'h38, 8'h3A, 8'h3C};

    // ==================================================================
    // Field positions
    localparam int CLKSEL_LSB = 1;  // Prescaler select in control A
    localparam int CHEN_LSB   = 4;  // Channel output enables in control B
    localparam int CMD_LSB    = 2;  // Command field in control E
    localparam int LOCK_BIT   = 1;  // update_lock
    localparam int DIR_BIT    = 0;  // Count direction
    localparam int FLAG_OVERFLOW = 0; // overflow_flag position
    localparam int FLAG_CMP   = 4;  // First compare flag position

    // ==================================================================
    // Reset values and prescaler table
    localparam logic [15:0] ACT_RST [4] = '{16'hFFFF, 16'h0000,
                                           16'h0000, 16'h0000};
    localparam logic [15:0] BUF_RST      = 16'h0000;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [9:0]  DIV_MASK [8] = '{10'h000, 10'h001, 10'h003,
        10'h007, 10'h00F, 10'h03F, 10'h0FF, 10'h3FF};

    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        WG_NORMAL            = 3'h0,
        FREQUENCY_MODE       = 3'h1,
        SINGLE_RAMP_PWM      = 3'h3,
        DUAL_RAMP_OVF_HIGH   = 3'h5,
        DUAL_RAMP_OVF_BOTH   = 3'h6,
        DUAL_RAMP_OVF_LOW    = 3'h7
    } wave_mode_t;

    typedef enum logic [1:0] {
        CMD_NONE    = 2'h0,
        CMD_UPDATE  = 2'h1,
        CMD_RESTART = 2'h2,
        CMD_HARD    = 2'h3
    } command_t;

    typedef struct packed {
        logic [9:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } apb_req_t;

endpackage

// *** verification/test_waveform_timer_control.sv ***
// Self-checking bench of the waveform timer control block
module test_waveform_timer_control
    import waveform_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==================================================================
    // Stimulus, observation and bookkeeping
    logic        clock;          // 200 MHz system clock
    logic        srst;           // Synchronous reset
    logic        psel;           // APB select
    logic        penable;        // APB enable
    logic        pwrite;         // APB direction
    logic [9:0]  paddr;          // APB byte address
    logic [31:0] pwdata;         // APB write data
    logic [31:0] prdata;         // APB read data
    logic        pready;         // APB ready
    logic        pslverr;        // APB error
    logic        irq;            // Level interrupt
    logic [2:0]  woPin;          // Pad waveforms
    logic [2:0]  woPinEn;        // Pad enables
    logic [2:0]  woLogic;        // Logic block waveforms
    logic [31:0] rdv;            // Last read data taken
    logic        errv;           // Last error taken
    int          mismatches;     // Failed comparisons
    int          samplesChecked; // All comparisons
    int          mCtrlE;         // Model of lock and direction bits
    int          mOut;           // Model of the override values
    int          v;              // Random scratch

    waveform_timer_control u_dut (
        .clock   (clock),
        .srst    (srst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq),
        .woPin   (woPin),
        .woPinEn (woPinEn),
        .woLogic (woLogic)
    );

    // ==================================================================
    // Clock and watchdog; a hang counts as a failure
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        wrapUp();
    end

    // ==================================================================
    // Shared tasks
    task automatic wrapUp();
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        samplesChecked++;
        if (seen !== expv) begin
            mismatches++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, expv);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            wrapUp();
        end
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] expv);
        xfer(1'b0, idx, 32'h0);
        chk(rdv, expv);
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        mCtrlE = 0;
        v = $urandom(54);
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        // Reset values of the output, split, control E and buffer valid registers and the period
        for (int i = 2; i <= 6; i++) rdChk(8'(i), 32'h0);
        rdChk(ACT_IDX[0], 32'h0000FFFF);
        // Aliases, with an idle forced update riding on each set write
        for (int i = 0; i < 8; i++) begin
            v = $urandom & 3;
            if (i % 2 == 0) begin
                xfer(1'b1, IDX_ESET, 32'(v | 4));
                mCtrlE = mCtrlE | v;
            end else begin
                xfer(1'b1, IDX_ECLR, 32'(v));
                mCtrlE = mCtrlE & ~v;
            end
            rdChk(IDX_ESET, mCtrlE);
            rdChk(IDX_ECLR, mCtrlE);
        end
        // Direction written by software, then cleared by a restart
        xfer(1'b1, IDX_ESET, 32'h1);
        rdChk(IDX_ESET, mCtrlE | 1);
        xfer(1'b1, IDX_ESET, 32'({CMD_RESTART, 2'b00}));
        mCtrlE = mCtrlE & 2;
        rdChk(IDX_ESET, mCtrlE);
        xfer(1'b1, IDX_ECLR, 32'h3);
        mCtrlE = 0;
        // Override while stopped, with and without pad enables
        mOut = $urandom & 7;
        xfer(1'b1, IDX_CTRLB, 32'h73);
        xfer(1'b1, IDX_OUTVAL, 32'(mOut));
        repeat (4) @(posedge clock);
        chk(woPin, mOut);
        chk(woPinEn, 32'h7);
        xfer(1'b1, IDX_CTRLB, 32'h03);
        repeat (4) @(posedge clock);
        chk(woPinEn, 32'h0);
        chk(woLogic, mOut);
        // Split mode takes the pads away
        xfer(1'b1, IDX_CTRLB, 32'h73);
        xfer(1'b1, IDX_SPLIT, 32'h1);
        repeat (4) @(posedge clock);
        chk(woPinEn, 32'h0);
        xfer(1'b1, IDX_SPLIT, 32'h0);
        // Unmapped index is refused
        xfer(1'b0, 8'h10, 32'h0);
        chk(errv, 32'h1);
        chk(rdv, 32'h0);
        // Running in normal mode with the update locked
        xfer(1'b1, ACT_IDX[0], 32'h7);
        xfer(1'b1, IDX_CTRLB, 32'h70);
        xfer(1'b1, IDX_MASK, 32'h1);
        xfer(1'b1, IDX_ESET, 32'h2);
        mCtrlE = 2;
        xfer(1'b1, BUF_IDX[0], 32'h5);
        xfer(1'b1, IDX_CTRLA, 32'h1);
        repeat (4) @(posedge clock);
        chk(woPinEn, 32'h0);
        v = 0;
        while (irq !== 1'b1 && v < 200) begin
            @(posedge clock);
            v++;
        end
        if (v >= 200) begin
            mismatches++;
            wrapUp();
        end
        chk(irq, 32'h1);
        repeat (40) @(posedge clock);
        rdChk(ACT_IDX[0], 32'h7);
        rdChk(IDX_FCLR, 32'h1);
        // Hard reset is ignored while running; forced update passes lock
        xfer(1'b1, IDX_ESET, 32'({CMD_HARD, 2'b00}));
        rdChk(IDX_ESET, mCtrlE);
        xfer(1'b1, IDX_ESET, 32'({CMD_UPDATE, 2'b00}));
        rdChk(ACT_IDX[0], 32'h5);
        rdChk(IDX_FCLR, 32'h0);
        // Masked, then cleared interrupt
        xfer(1'b1, IDX_MASK, 32'h0);
        repeat (3) @(posedge clock);
        chk(irq, 32'h0);
        xfer(1'b1, IDX_CTRLA, 32'h0);
        xfer(1'b0, IDX_FLAGS, 32'h0);
        chk(rdv[0], 32'h1);
        xfer(1'b1, IDX_FLAGS, 32'h71);
        rdChk(IDX_FLAGS, 32'h0);
        xfer(1'b1, IDX_MASK, 32'h1);
        repeat (3) @(posedge clock);
        chk(irq, 32'h0);
        // Hard reset once stopped
        xfer(1'b1, IDX_ESET, 32'({CMD_HARD, 2'b00}));
        rdChk(IDX_ESET, 32'h0);
        rdChk(ACT_IDX[0], 32'h0000FFFF);
        // Dual ramp on a slow prescaler: overflow at top, update at bottom
        xfer(1'b1, ACT_IDX[0], 32'h4);
        xfer(1'b1, BUF_IDX[0], 32'h6);
        xfer(1'b1, IDX_CTRLB, 32'h75);
        xfer(1'b1, IDX_CTRLA, 32'h0F);
        v = 0;
        do begin
            xfer(1'b0, IDX_ESET, 32'h0);
            v++;
        end while (rdv[DIR_BIT] !== 1'b1 && v < 3000);
        if (v >= 3000) begin
            mismatches++;
            wrapUp();
        end
        chk(woPinEn, 32'h7);
        rdChk(ACT_IDX[0], 32'h4);
        rdChk(IDX_FCLR, 32'h1);
        xfer(1'b0, IDX_FLAGS, 32'h0);
        chk(rdv[0], 32'h1);
        xfer(1'b1, IDX_FLAGS, 32'h71);
        // Long enough to pass bottom, short of the next top
        repeat (5000) @(posedge clock);
        rdChk(ACT_IDX[0], 32'h6);
        rdChk(IDX_FCLR, 32'h0);
        xfer(1'b0, IDX_FLAGS, 32'h0);
        chk(rdv[0], 32'h0);
        rdChk(IDX_ESET, 32'h0);
        wrapUp();
    end

endmodule // test_waveform_timer_control
